// *** rtl/fbsr_fifo.sv ***
// snapshot fifo with registered read data
`timescale 1ns/1ns
`default_nettype none
module fbsr_fifo #(
    parameter int WIDTH = 4,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst_b,
    // fill side
    input  wire logic             inValid,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  inReady,
    // drain side
    output logic                  outValid,
    output logic      [WIDTH-1:0] outData,
    input  wire logic             outReady
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wrPtr;
        logic [PW-1:0]               rdPtr;
        logic [CW-1:0]               count;
        logic                        inReady;
        logic [WIDTH-1:0]            outData;
        logic                        outValid;
    } fbsr_fifo_state_type;

    localparam fbsr_fifo_state_type RESET_STATE = '{
        mem: '0, wrPtr: '0, rdPtr: '0, count: '0,
        inReady: 1'h1, outData: '0, outValid: 1'h0};

    fbsr_fifo_state_type state;
    fbsr_fifo_state_type next_state;
    logic                push;
    logic                pop;

    // wraps for depths that are not a power of two
    function automatic logic [PW-1:0] ptrInc(input logic [PW-1:0] p);
        ptrInc = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'h1);
    endfunction

    always_comb begin
        next_state = state;
        push = inValid && state.inReady;
        pop = (state.count != '0) && (!state.outValid || outReady);
        if (state.outValid && outReady) begin
            next_state.outValid = 1'h0;
        end
        if (pop) begin
            next_state.outData = state.mem[state.rdPtr];
            next_state.outValid = 1'h1;
            next_state.rdPtr = ptrInc(state.rdPtr);
        end
        if (push) begin
            next_state.mem[state.wrPtr] = inData;
            next_state.wrPtr = ptrInc(state.wrPtr);
        end
        next_state.count = CW'(state.count + CW'(push) - CW'(pop));
        next_state.inReady = (next_state.count < CW'(DEPTH));
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= RESET_STATE;
        end else begin
            state <= next_state;
        end
    end

    assign inReady  = state.inReady;
    assign outValid = state.outValid;
    assign outData  = state.outData;

    a_fifo_full_stall: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (state.count == CW'(DEPTH)) |-> !inReady)
        else $error("fifo full but still ready");
endmodule
`default_nettype wire

// *** rtl/fbsr_shift_register.sv ***
// four stage shift register with parallel load and snapshot buffer
//
// Functional notes
// RQ1: two clocked modes, shift right or parallel load, chosen by parallel_load_n.
// RQ2: shift mode: each stage moves one place up, stage 0 from serial inputs.
// RQ3: load mode: parallel_in copied to all stages, serial inputs ignored.
// RQ4: serial inputs both high set stage 0, both low clear it.
// RQ5: set high with hold_n low toggles stage 0.
// RQ6: set low with hold_n high keeps stage 0 while others shift.
// RQ7: clear_n low forces all stages low at once, overriding everything.
// RQ8: last_stage_out_n is always the inverse of stage 3.
// RQ9: stages change only on a rising shift_clock edge or through clear.
// RQ10: inputs matter only at the clock edge, never between edges.
// RQ11: shift left is external wiring of outputs to lower parallel inputs.
`timescale 1ns/1ns
`default_nettype none
module fbsr_shift_register
    import fbsr_pkg::*;
#(
    parameter int SNAP_DEPTH = SNAPSHOT_DEPTH
) (
    // clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   rst_b,
    // register control
    input  wire logic                   shift_clock,
    input  wire logic                   clear_n,
    input  wire logic                   parallel_load_n,
    // data inputs
    input  wire logic [STAGE_WIDTH-1:0] parallel_in,
    input  wire logic                   first_stage_set_in,
    input  wire logic                   first_stage_hold_n,
    // register outputs
    output logic      [STAGE_WIDTH-1:0] stage_out,
    output logic                        last_stage_out_n,
    // snapshot stream
    output logic                        snapshotValid,
    output logic      [STAGE_WIDTH-1:0] snapshotData,
    input  wire logic                   snapshotReady,
    output logic                        captureReady
);
    localparam fbsr_state_type RESET_STATE = '{
        stage: STAGE_RESET, lastN: LAST_N_RESET, prevClock: PREV_CLOCK_RESET};

    fbsr_state_type state;
    fbsr_state_type next_state;
    logic           clearAll_b;
    logic           clockRise;
    logic           firstNext;
    logic           captureValid;

    // clear acts as a second asynchronous reset of the register state
    assign clearAll_b = rst_b & clear_n; // [RQ7]

    always_comb begin
        next_state = state;
        // shift_clock is a pin sampled on ref_clk; only a seen low-to-high counts
        clockRise = shift_clock && !state.prevClock; // [RQ9]
        next_state.prevClock = shift_clock;
        case ({first_stage_set_in, first_stage_hold_n})
            FIRST_SET:    firstNext = 1'h1; // [RQ4]
            FIRST_CLEAR:  firstNext = 1'h0; // [RQ4]
            FIRST_TOGGLE: firstNext = ~state.stage[0]; // [RQ5]
            FIRST_KEEP:   firstNext = state.stage[0]; // [RQ6]
            default:      firstNext = state.stage[0];
        endcase
        // inputs are looked at only in the edge cycle
        if (clockRise) begin // [RQ10]
            if (!parallel_load_n) begin // [RQ1]
                next_state.stage = parallel_in; // [RQ3]
            end else begin
                next_state.stage = {state.stage[STAGE_WIDTH-2:0], firstNext}; // [RQ2]
            end
        end
        next_state.lastN = ~next_state.stage[LAST_STAGE]; // [RQ8]
        // a snapshot is offered to the buffer whenever the register is clocked
        captureValid = clockRise && clear_n;
    end

    always_ff @(posedge ref_clk or negedge clearAll_b) begin
        if (!clearAll_b) begin
            state <= RESET_STATE; // [RQ7]
        end else begin
            state <= next_state;
        end
    end

    assign stage_out        = state.stage;
    assign last_stage_out_n = state.lastN;

    // a full buffer drops snapshots; the register itself never waits
    fbsr_fifo #(
        .WIDTH (STAGE_WIDTH),
        .DEPTH (SNAP_DEPTH)
    ) snapshotFifo (
        .ref_clk  (ref_clk),
        .rst_b    (rst_b),
        .inValid  (captureValid),
        .inData   (next_state.stage),
        .inReady  (captureReady),
        .outValid (snapshotValid),
        .outData  (snapshotData),
        .outReady (snapshotReady)
    );

    a_shift_stage_move: assert property (@(posedge ref_clk) disable iff (!clearAll_b) // [RQ2]
        (clockRise && parallel_load_n) |=>
        (stage_out[STAGE_WIDTH-1:1] == $past(stage_out[STAGE_WIDTH-2:0])))
        else $error("shift did not move stages up");

    a_load_copy_all: assert property (@(posedge ref_clk) disable iff (!clearAll_b) // [RQ3]
        (clockRise && !parallel_load_n) |=> (stage_out == $past(parallel_in)))
        else $error("parallel load mismatch");

    a_load_last_out: assert property (@(posedge ref_clk) disable iff (!clearAll_b) // [RQ8]
        (clockRise && !parallel_load_n) |=>
        (last_stage_out_n == !$past(parallel_in[LAST_STAGE])))
        else $error("inverted last stage wrong after load");

    a_first_set_clear: assert property (@(posedge ref_clk) disable iff (!clearAll_b) // [RQ4]
        (clockRise && parallel_load_n && (first_stage_set_in == first_stage_hold_n))
        |=> (stage_out[0] == $past(first_stage_set_in)))
        else $error("stage 0 not set or cleared");

    a_first_toggle: assert property (@(posedge ref_clk) disable iff (!clearAll_b) // [RQ5]
        (clockRise && parallel_load_n && first_stage_set_in && !first_stage_hold_n)
        |=> (stage_out[0] != $past(stage_out[0])))
        else $error("stage 0 did not toggle");

    a_first_keep: assert property (@(posedge ref_clk) disable iff (!clearAll_b) // [RQ6]
        (clockRise && parallel_load_n && !first_stage_set_in && first_stage_hold_n)
        |=> ($stable(stage_out[0]) && (stage_out[1] == $past(stage_out[0]))))
        else $error("stage 0 not kept");

    a_clear_force_low: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RQ7]
        !clear_n |-> ((stage_out == STAGE_RESET) && last_stage_out_n))
        else $error("clear did not force stages low");

    a_last_inverse: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RQ8]
        last_stage_out_n == !stage_out[LAST_STAGE])
        else $error("inverted last stage wrong");

    a_no_edge_hold: assert property (@(posedge ref_clk) disable iff (!clearAll_b) // [RQ9]
        !clockRise |=> $stable(stage_out))
        else $error("stages changed without a clock edge");

    a_mode_only_edge: assert property (@(posedge ref_clk) disable iff (!clearAll_b) // [RQ1]
        (!shift_clock ##1 shift_clock) |=>
        (stage_out == ($past(parallel_load_n) ?
            {$past(stage_out[STAGE_WIDTH-2:0]), stage_out[0]} : $past(parallel_in))))
        else $error("edge did not apply selected mode");

    // scrambled inputs away from an edge must leave the stages alone
    a_input_between_edges: assert property (@(posedge ref_clk) disable iff (!clearAll_b) // [RQ10]
        (!clockRise && ($changed(parallel_in) || $changed(parallel_load_n)))
        |=> $stable(stage_out))
        else $error("input change between edges reached the stages");

    a_snapshot_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (snapshotValid && !snapshotReady) |=> (snapshotValid && $stable(snapshotData)))
        else $error("snapshot changed while stalled");
endmodule
`default_nettype wire

// *** shared/fbsr_pkg.sv ***
// shared constants for the four bit shift register block
package fbsr_pkg;

    // number of register stages
    localparam int STAGE_WIDTH = 4;

    // index of the last stage, which feeds the inverted output
    localparam int LAST_STAGE = STAGE_WIDTH - 1;

    // values after reset or clear
    localparam logic [STAGE_WIDTH-1:0] STAGE_RESET      = 4'h0;
    localparam logic                   LAST_N_RESET     = 1'h1;

    // taken as high so that a clock already high at release is no edge
    localparam logic                   PREV_CLOCK_RESET = 1'h1;

    // snapshot buffer shape
    localparam int SNAPSHOT_DEPTH = 16;

    // first stage serial input encodings, {set, hold_n}
    localparam logic [1:0] FIRST_SET    = 2'h3;
    localparam logic [1:0] FIRST_CLEAR  = 2'h0;
    localparam logic [1:0] FIRST_TOGGLE = 2'h2;
    localparam logic [1:0] FIRST_KEEP   = 2'h1;

    // registered state of the shift register
    typedef struct packed {
        logic [STAGE_WIDTH-1:0] stage;
        logic                   lastN;
        logic                   prevClock;
    } fbsr_state_type;

endpackage

// *** verification/fbsr_consumer.sv ***
// snapshot consumer model that can stall the stream
`timescale 1ns/1ns
`default_nettype none
module fbsr_consumer
    import fbsr_pkg::*;
(
    // clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   rst_b,
    // stall request from the bench
    input  wire logic                   stall,
    // snapshot stream
    input  wire logic                   snapshotValid,
    input  wire logic [STAGE_WIDTH-1:0] snapshotData,
    output logic                        snapshotReady
);
    logic [STAGE_WIDTH-1:0] got[$];
    initial snapshotReady = 1'h0;
    // nonblocking on the edge, so fifo and taker see the same ready value
    always @(posedge ref_clk) begin
        snapshotReady <= ~stall;
    end
    always @(posedge ref_clk) begin
        if (rst_b && snapshotValid && snapshotReady) begin
            got.push_back(snapshotData);
        end
    end
endmodule
`default_nettype wire

// *** verification/tb_four_bit_shift_register.sv ***
// self-checking bench for the four bit shift register
`timescale 1ns/1ns
`default_nettype none
module tb_four_bit_shift_register
    import fbsr_pkg::*;
;
    typedef struct packed {
        logic plN; logic [3:0] pin; logic [1:0] sh; logic [3:0] exp;
    } fbsr_row_type;
    logic refClk, rstB, shiftClock, clearN, loadN, setIn, holdN, stall;
    logic snapValid, snapReady, capReady, lastN;
    logic [3:0] parIn, stageOut, snapData;
    int nErrors = 0;
    int nTests = 0;
    int base;
    // rows start from the cleared register, each row builds on the last
    fbsr_row_type rows[9] = '{
        '{1'h0, 4'hA, FIRST_SET, 4'hA}, '{1'h1, 4'h0, FIRST_SET, 4'h5},
        '{1'h1, 4'hF, FIRST_CLEAR, 4'hA}, '{1'h1, 4'h0, FIRST_TOGGLE, 4'h5},
        '{1'h1, 4'h0, FIRST_TOGGLE, 4'hA}, '{1'h1, 4'h0, FIRST_KEEP, 4'h4},
        '{1'h0, 4'hF, FIRST_CLEAR, 4'hF}, '{1'h1, 4'h0, FIRST_KEEP, 4'hF},
        '{1'h1, 4'h0, FIRST_CLEAR, 4'hE}};

    fbsr_shift_register #(.SNAP_DEPTH(2)) i_fbsr_shift_register (
        .ref_clk(refClk), .rst_b(rstB), .shift_clock(shiftClock), .clear_n(clearN),
        .parallel_load_n(loadN), .parallel_in(parIn), .first_stage_set_in(setIn),
        .first_stage_hold_n(holdN), .stage_out(stageOut), .last_stage_out_n(lastN),
        .snapshotValid(snapValid), .snapshotData(snapData),
        .snapshotReady(snapReady), .captureReady(capReady));
    fbsr_consumer i_fbsr_consumer (
        .ref_clk(refClk), .rst_b(rstB), .stall(stall), .snapshotValid(snapValid),
        .snapshotData(snapData), .snapshotReady(snapReady));

    initial begin
        refClk = 1'h0;
        forever #4 refClk = ~refClk;
    end

    task automatic check(input logic [3:0] got, input logic [3:0] exp);
        nTests++;
        if (got !== exp) begin
            nErrors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one register clock pulse; inputs are scrambled while the clock stays high
    task automatic pulse(input logic pl, input logic [3:0] p, input logic [1:0] sh);
        @(negedge refClk);
        loadN = pl;
        parIn = p;
        {setIn, holdN} = sh;
        shiftClock = 1'h1;
        @(negedge refClk);
        loadN = ~pl;
        parIn = ~p;
        {setIn, holdN} = ~sh;
        @(negedge refClk);
        shiftClock = 1'h0;
        @(negedge refClk);
    endtask

    task automatic final_report;
        $display("counts: %0d compares, %0d mismatches", nTests, nErrors);
        if (nErrors == 0 && nTests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        #20000;
        nErrors++;
        final_report();
    end

    initial begin
        rstB = 1'h0; shiftClock = 1'h0; clearN = 1'h1; loadN = 1'h1;
        setIn = 1'h0; holdN = 1'h1; stall = 1'h0; parIn = 4'h0;
        repeat (6) @(negedge refClk);
        rstB = 1'h1;
        check(stageOut, 4'h0);
        check({3'h0, lastN}, 4'h1);
        check({2'h0, snapValid, capReady}, 4'h1);
        $display("test reset done");
        for (int i = 0; i < 9; i++) begin
            pulse(rows[i].plN, rows[i].pin, rows[i].sh);
            check(stageOut, rows[i].exp);
            check({3'h0, lastN}, {3'h0, ~rows[i].exp[3]});
        end
        repeat (4) @(negedge refClk);
        check(4'(i_fbsr_consumer.got.size()), 4'h9);
        for (int i = 0; i < 9; i++) begin
            check(i_fbsr_consumer.got[i], rows[i].exp);
        end
        $display("test table done");
        clearN = 1'h0;
        #1;
        check(stageOut, 4'h0);
        check({3'h0, lastN}, 4'h1);
        pulse(1'h0, 4'hF, FIRST_SET);
        check(stageOut, 4'h0);
        clearN = 1'h1;
        repeat (4) @(negedge refClk);
        check(4'(i_fbsr_consumer.got.size()), 4'h9);
        $display("test clear done");
        pulse(1'h0, 4'h9, FIRST_SET);
        pulse(1'h0, {1'h0, stageOut[3:1]}, FIRST_SET);
        check(stageOut, 4'h4);
        $display("test shift left done");
        repeat (4) @(negedge refClk);
        base = i_fbsr_consumer.got.size();
        stall = 1'h1;
        // memory holds two words and the output register one, the rest drop
        for (int k = 1; k <= 5; k++) begin
            pulse(1'h0, k[3:0], FIRST_CLEAR);
        end
        check({3'h0, capReady}, 4'h0);
        check(stageOut, 4'h5);
        stall = 1'h0;
        repeat (8) @(negedge refClk);
        check(4'(i_fbsr_consumer.got.size() - base), 4'h3);
        for (int k = 0; k < 3; k++) begin
            check(i_fbsr_consumer.got[base + k], k[3:0] + 4'h1);
        end
        check({3'h0, snapValid}, 4'h0);
        $display("test full buffer done");
        final_report();
    end
endmodule
`default_nettype wire
